/* File: core/otmon_regs.vh */
`ifndef OTMON_REGS_VH
`define OTMON_REGS_VH
// temperature sample width, signed whole degrees celsius
`define OTMON_TEMP_W        8
// thermal state encoding
`define OTMON_ST_W          2
`define OTMON_ST_NORMAL     2'h0
`define OTMON_ST_WARNING    2'h1
`define OTMON_ST_FAULT      2'h2
// thresholds in degrees celsius
`define OTMON_WARN_ENTER    8'sh46
`define OTMON_WARN_EXIT     8'sh41
`define OTMON_FAULT_ENTER   8'sh50
`define OTMON_FAULT_EXIT    8'sh4B
// reset value of the reported temperature
`define OTMON_TEMP_RESET    8'h00
// reset values of the acquisition gate and the event pulse
`define OTMON_ALLOW_RESET   1'h1
`define OTMON_EVENT_RESET   1'h0
`endif

/* File: core/otmon_monitor.v */
// What this block does
// - the latest sensor temperature is held and offered to software.
// - thermal state is exactly one of normal, warning or fault.
// - below 70 degrees with no other transition, state stays normal, acquisition allowed.
// - above 70 and up to 80 degrees normal becomes warning; acquisition continues.
// - warning returns to normal only once temperature drops below 65 degrees.
// - above 80 degrees state becomes fault and acquisition is suspended.
// - in fault acquisition stays suspended until temperature falls below 75 degrees.
// - with monitoring enabled, each state change on a sample raises one event pulse; a reset raises none.
`timescale 1ns/1ps
`include "otmon_regs.vh"

module otmon_monitor
(
    // clock and reset
    input  wire                       clk,
    input  wire                       reset,
    // sensor sample, taken when valid is high
    input  wire [`OTMON_TEMP_W-1:0]   sensor_temp,
    input  wire                       sensor_valid,
    // monitoring control
    input  wire                       thermal_watch_enable,
    // status towards software and acquisition logic
    output reg  [`OTMON_TEMP_W-1:0]   current_temp,
    output reg  [`OTMON_ST_W-1:0]     thermal_state,
    output reg                        acquisition_allowed,
    output reg                        thermal_state_change_event
);

    // state codes of the thermal state machine
    localparam [`OTMON_ST_W-1:0]   ST_NORMAL      = `OTMON_ST_NORMAL;
    localparam [`OTMON_ST_W-1:0]   ST_WARNING     = `OTMON_ST_WARNING;
    localparam [`OTMON_ST_W-1:0]   ST_FAULT       = `OTMON_ST_FAULT;

    // thresholds in whole degrees, always compared strictly
    localparam [`OTMON_TEMP_W-1:0] WARN_ENTER     = `OTMON_WARN_ENTER;
    localparam [`OTMON_TEMP_W-1:0] WARN_EXIT      = `OTMON_WARN_EXIT;
    localparam [`OTMON_TEMP_W-1:0] FAULT_ENTER    = `OTMON_FAULT_ENTER;
    localparam [`OTMON_TEMP_W-1:0] FAULT_EXIT     = `OTMON_FAULT_EXIT;

    // values loaded while reset is held
    localparam [`OTMON_TEMP_W-1:0] TEMP_AT_RESET  = `OTMON_TEMP_RESET;
    localparam                     ALLOW_AT_RESET = `OTMON_ALLOW_RESET;
    localparam                     EVENT_AT_RESET = `OTMON_EVENT_RESET;

    // next values of every registered output
    reg  [`OTMON_ST_W-1:0]         next_thermal_state;
    reg  [`OTMON_TEMP_W-1:0]       next_current_temp;
    reg                            next_acquisition_allowed;
    reg                            next_thermal_state_change_event;

    // sample strobe and threshold crossings of the present sample
    wire                           sample_taken;
    wire                           over_fault_enter;
    wire                           over_warn_enter;
    wire                           under_fault_exit;
    wire                           under_warn_exit;
    wire                           state_moves;

    // signed compare helper, a strictly above b
    function above;
        input [`OTMON_TEMP_W-1:0] a;
        input [`OTMON_TEMP_W-1:0] b;
        begin
            above = ($signed(a) > $signed(b));
        end
    endfunction

    // cycles without a valid sample leave everything but the event pulse as it is
    assign sample_taken = sensor_valid;

    // strict comparisons, so a sample equal to a threshold does not cross that threshold
    assign over_fault_enter = above(sensor_temp, FAULT_ENTER);
    assign over_warn_enter  = above(sensor_temp, WARN_ENTER);
    assign under_fault_exit = above(FAULT_EXIT, sensor_temp);
    assign under_warn_exit  = above(WARN_EXIT, sensor_temp);

    // state transitions driven by each new sample
    always @*
    begin
        next_thermal_state = thermal_state;
        if (sample_taken)
        begin
            case (thermal_state)
                ST_NORMAL:
                begin
                    if (over_fault_enter)
                    begin
                        next_thermal_state = ST_FAULT;
                    end
                    else if (over_warn_enter)
                    begin
                        next_thermal_state = ST_WARNING;
                    end
                    else
                    begin
                        next_thermal_state = ST_NORMAL;
                    end
                end
                ST_WARNING:
                begin
                    if (over_fault_enter)
                    begin
                        next_thermal_state = ST_FAULT;
                    end
                    else if (under_warn_exit)
                    begin
                        next_thermal_state = ST_NORMAL;
                    end
                    else
                    begin
                        next_thermal_state = ST_WARNING;
                    end
                end
                ST_FAULT:
                begin
                    if (under_fault_exit)
                    begin
                        next_thermal_state = ST_WARNING;
                    end
                    else
                    begin
                        next_thermal_state = ST_FAULT;
                    end
                end
                default:
                begin
                    next_thermal_state = ST_NORMAL;
                end
            endcase
        end
    end

    // any difference between next and present state is a change
    assign state_moves = (next_thermal_state != thermal_state);

    // software readable temperature follows every accepted sample
    always @*
    begin
        next_current_temp = current_temp;
        if (sample_taken)
        begin
            next_current_temp = sensor_temp;
        end
    end

    // acquisition is held off exactly while the machine sits in fault
    always @*
    begin
        if (next_thermal_state == ST_FAULT)
        begin
            next_acquisition_allowed = 1'h0;
        end
        else
        begin
            next_acquisition_allowed = 1'h1;
        end
    end

    // one pulse per change; changes while disabled are never reported later
    always @*
    begin
        if (thermal_watch_enable && state_moves)
        begin
            next_thermal_state_change_event = 1'h1;
        end
        else
        begin
            next_thermal_state_change_event = 1'h0;
        end
    end

    // thermal state register, normal out of reset
    always @(posedge clk)
    begin
        if (reset)
        begin
            thermal_state <= ST_NORMAL;
        end
        else
        begin
            thermal_state <= next_thermal_state;
        end
    end

    // reported temperature register
    always @(posedge clk)
    begin
        if (reset)
        begin
            current_temp <= TEMP_AT_RESET;
        end
        else
        begin
            current_temp <= next_current_temp;
        end
    end

    // acquisition gate register, open out of reset
    always @(posedge clk)
    begin
        if (reset)
        begin
            acquisition_allowed <= ALLOW_AT_RESET;
        end
        else
        begin
            acquisition_allowed <= next_acquisition_allowed;
        end
    end

    // event register; reset drops a pending pulse
    always @(posedge clk)
    begin
        if (reset)
        begin
            thermal_state_change_event <= EVENT_AT_RESET;
        end
        else
        begin
            thermal_state_change_event <= next_thermal_state_change_event;
        end
    end

endmodule // otmon_monitor

/* File: sim/otmon_assertions.sv */
`timescale 1ns/1ps
module otmon_chk
(
    // all ports of the monitor
    input wire       clk, reset, sensor_valid, thermal_watch_enable,
    input wire       acquisition_allowed, thermal_state_change_event,
    input wire [7:0] sensor_temp, current_temp,
    input wire [1:0] thermal_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // signed view of the sample
    wire signed [7:0] t = $signed(sensor_temp);
    sequence s_hot;
        sensor_valid && t > 80 && thermal_state != 2'h2;
    endsequence
    a_state_legal: assert property (thermal_state != 2'h3) else $error("bad state");
    a_allow_fault: assert property (acquisition_allowed == (thermal_state != 2'h2))
        else $error("allow wrong");
    a_fault_enter: assert property (s_hot |=> thermal_state == 2'h2) else $error("no fault");
    a_warn_enter: assert property (sensor_valid && thermal_state == 2'h0 && t > 70 && t <= 80
        |=> thermal_state == 2'h1) else $error("no warning");
    a_warn_exit: assert property (sensor_valid && thermal_state == 2'h1 && t < 65
        |=> thermal_state == 2'h0) else $error("no normal");
    a_fault_exit: assert property (sensor_valid && thermal_state == 2'h2 && t < 75
        |=> thermal_state == 2'h1) else $error("bad resume");
    a_idle_hold: assert property (!sensor_valid |=> $stable(thermal_state)
        && $stable(current_temp)) else $error("idle change");
    a_temp_take: assert property (sensor_valid |=> current_temp == $past(sensor_temp))
        else $error("temp lost");
    a_event_pulse: assert property (thermal_state_change_event ==
        ($changed(thermal_state) && $past(thermal_watch_enable) && !$past(reset)))
        else $error("event wrong");
    a_norm_hold: assert property (sensor_valid && thermal_state == 2'h0 && t <= 70
        |=> thermal_state == 2'h0) else $error("left normal");
    a_warn_hold: assert property (sensor_valid && thermal_state == 2'h1 && t >= 65
        && t <= 80 |=> thermal_state == 2'h1) else $error("left warning");
    a_fault_hold: assert property (sensor_valid && thermal_state == 2'h2 && t >= 75
        |=> thermal_state == 2'h2) else $error("left fault");
endmodule // otmon_chk
bind otmon_monitor otmon_chk u_chk (.clk(clk), .reset(reset), .sensor_valid(sensor_valid),
    .thermal_watch_enable(thermal_watch_enable), .acquisition_allowed(acquisition_allowed),
    .thermal_state_change_event(thermal_state_change_event), .sensor_temp(sensor_temp),
    .current_temp(current_temp), .thermal_state(thermal_state));

/* File: sim/over_temperature_monitor_bench.sv */
`timescale 1ns/1ps
module over_temperature_monitor_bench;
    reg         clk = 0, reset = 1, sensor_valid = 0, thermal_watch_enable = 0, ee = 0;
    reg  [7:0]  sensor_temp = 8'h00, et = 8'h00;
    reg  [1:0]  es = 2'h0;
    reg  [31:0] r;
    wire [7:0]  current_temp;
    wire [1:0]  thermal_state;
    wire        acquisition_allowed, thermal_state_change_event;
    integer     n_mismatch = 0, total_checks = 0, seed = 32'hec44d74f, i;
    // threshold edge samples played first
    localparam [79:0] CT = 80'h4647414051_4B4A505140;
    otmon_monitor u_dut (.clk(clk), .reset(reset), .sensor_temp(sensor_temp),
        .sensor_valid(sensor_valid), .thermal_watch_enable(thermal_watch_enable),
        .current_temp(current_temp), .thermal_state(thermal_state),
        .acquisition_allowed(acquisition_allowed),
        .thermal_state_change_event(thermal_state_change_event));
    // expected next state with strict thresholds
    function [1:0] nxt(input [1:0] s, input signed [7:0] t);
        nxt = t > 80 ? 2'h2 : s == 2'h2 ? (t < 75 ? 2'h1 : 2'h2) :
              s == 2'h1 ? (t < 65 ? 2'h0 : 2'h1) : (t > 70 ? 2'h1 : 2'h0);
    endfunction
    task final_report;
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input ok);
        total_checks = total_checks + 1;
        if (!ok) begin n_mismatch = n_mismatch + 1; $display("CHECK FAILED %0t mismatch", $time); end
    endtask
    initial forever #5 clk = ~clk;
    initial begin #100000 n_mismatch = n_mismatch + 1; final_report; end
    // corner table, then random samples around the thresholds, one reset mid-run
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        for (i = 0; i < 3000; i = i + 1) begin
            @(posedge clk);
            r = $random(seed);
            reset <= (i == 1500);
            sensor_temp <= i < 10 ? CT[79-8*i-:8] : r[15:14] == 2'h0 ? r[23:16] : 8'h38 + r[12:8];
            sensor_valid <= i < 10 || r[0];
            thermal_watch_enable <= i < 10 || r[1] || r[2];
        end
        @(posedge clk);
        final_report;
    end
    // reference model on the sampling edge
    always @(posedge clk)
    begin
        if (reset) begin es <= 2'h0; et <= 8'h00; ee <= 1'b0; end
        else begin
            ee <= sensor_valid && thermal_watch_enable && nxt(es, sensor_temp) != es;
            if (sensor_valid) begin et <= sensor_temp; es <= nxt(es, sensor_temp); end
        end
    end
    always @(negedge clk)
    begin
        chk(thermal_state === es);
        chk(current_temp === et);
        chk(thermal_state_change_event === ee);
        chk(acquisition_allowed === (es != 2'h2));
    end
endmodule // over_temperature_monitor_bench
